// ==== mailbox_pkg.sv ====
package mailbox_pkg;
	// ==========================================================
	// file geometry
	localparam int WORD_W = 16;
	localparam int NUM_WORDS = 16;
	localparam int IDX_W = 4;
	localparam logic [3:0] IDX_CMD = 4'h0;
	localparam logic [3:0] IDX_ERR = 4'h1;
	localparam logic [3:0] IDX_PAR = 4'h2;
	localparam logic [3:0] IDX_PAR2 = 4'h3;
	localparam logic [3:0] IDX_USER_FIRST = 4'h4;
	localparam logic [3:0] IDX_LAST = 4'hF;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	// ==========================================================
	// command word fields
	localparam int CMD_TEST_BIT = 15;
	localparam int CMD_HR_BIT = 14;
	localparam int SEL_W = 11;
	localparam int CTL_IDENT = 10;
	localparam int CTL_SHM_DIS = 8;
	localparam int CTL_SHM_REP = 7;
	localparam int CTL_SHM_EN = 6;
	localparam int CTL_CFG_REP = 4;
	localparam int CTL_DEBUG = 3;
	localparam int CTL_RESTART = 2;
	localparam int CTL_DMA = 1;
	localparam int CTL_TRAP = 0;
	localparam int DBG_EXIT = 15;
	localparam int DBG_PROCEED = 4;
	localparam int DBG_GO = 3;
	localparam int DBG_DEPOSIT = 2;
	localparam int DBG_REG = 1;
	localparam int DBG_MEM = 0;
	localparam int TEST_REGFILE = 10;
	localparam logic [15:0] TEST_UNUSED_MASK = 16'h7800;
	// ==========================================================
	// error/state word and parameter fields
	localparam int ERR_CMD_BIT = 15;
	localparam int ERR_DMA_BIT = 14;
	localparam logic [2:0] STATE_NONE = 3'b000;
	localparam logic [2:0] STATE_DEBUG = 3'b011;
	localparam logic [2:0] STATE_IDLE = 3'b100;
	localparam logic [15:0] RESTART_USE_SWITCH = 16'h0008;
	localparam logic [15:0] DBG_REG_LAST = 16'h0008;
	localparam int CFG_BOOT_LSB = 4;
	localparam int CFG_MEM_LSB = 1;
	localparam int SHM_BASE_W = 10;
	// ==========================================================
	// modes and external operations
	typedef enum logic [1:0] {MODE_CTRL, MODE_TEST, MODE_DEBUG} mode_t;
	typedef enum logic [3:0] {
		OP_NONE, OP_RESTART, OP_DMA, OP_TRAP, OP_TEST,
		OP_DBG_PROCEED, OP_DBG_GO, OP_DBG_DEPOSIT, OP_DBG_REG, OP_DBG_MEM
	} op_t;
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ZERO, ST_DONE} fsm_t;
endpackage : mailbox_pkg

// ==== two_port_command_mailbox.sv ====
`timescale 1ns/1ps
// Functional notes
// - sixteen 16-bit words, host and local ports
// - disabled file: host reads zero, read-only
// - disabled: writes time out, command word excepted
// - outside debug, bit 15 picks test, else control
// - control bit 3 enters debug until exit, proceed or go
// - bit 14 write resets locally, always
// - resets and debug go disable NMI
// - finished operation clears command word
// - one command bit at a time
// - identify writes board id to word two
// - sharing disable, error if already off
// - sharing report, error when disabled
// - sharing enable loads base and count
// - configuration report: switch and memory type
// - restart: 8 uses switch, over 8 invalid
// - DMA load sets error bit 14, status
// - trap uses PC and status words
// - one test bit, failures in word two
// - test mode bits 14:11 read zero
// - register-file test zeroes words 4-15
// - error word read-only from host
// - state field, 100 means idle
module two_port_command_mailbox
	import mailbox_pkg::*;
#(
	parameter logic [15:0] BOARD_ID = 16'h00A5 // arbitrary identification value
) (
	input wire logic sys_clk_i, // board clock
	input wire logic rstn_i, // async reset, active low
	input wire logic file_enable_i, // file enabled from host-side control
	input wire logic host_req_i, // host access request
	input wire logic host_we_i, // host write
	input wire logic [3:0] host_addr_i, // host word index
	input wire logic [15:0] host_wdata_i, // host write data
	output logic host_ack_o, // host access done
	output logic host_timeout_o, // host write refused
	output logic [15:0] host_rdata_o, // host read data
	input wire logic loc_req_i, // local access request
	input wire logic loc_we_i, // local write
	input wire logic [3:0] loc_addr_i, // local word index
	input wire logic [15:0] loc_wdata_i, // local write data
	output logic loc_ack_o, // local access done
	output logic [15:0] loc_rdata_o, // local read data
	input wire logic [3:0] boot_sw_i, // boot switch pins
	input wire logic [1:0] mem_type_i, // memory type straps
	input wire logic sw_reset_i, // software reset pulse
	input wire logic nmi_arm_i, // NMI enable pulse
	output logic nmi_enable_o, // NMI enabled
	output logic hard_reset_o, // board hard reset pulse
	output logic ext_start_o, // external operation start pulse
	output op_t ext_op_o, // external operation
	output logic [10:0] ext_sel_o, // test select
	output logic [15:0] ext_arg2_o, // word two argument
	output logic [15:0] ext_arg3_o, // word three argument
	input wire logic ext_done_i, // external operation done
	input wire logic ext_fail_i, // external operation failed
	input wire logic [15:0] ext_status_i, // external result
	output logic shm_enable_o, // shared memory enabled
	output logic [9:0] shm_base_o, // shared base address 22:13
	output logic [15:0] shm_blocks_o, // 8 KB blocks minus one
	output logic [2:0] board_state_o // state field
);
	// ==========================================================
	// reset release and pin synchronisers
	logic [1:0] rst_sync_r;
	logic rst_n;
	logic [5:0] pin_s1_r;
	logic [5:0] pin_s2_r;
	logic init_r;
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];
	// pins keep sampling through reset so the init copy is settled
	always_ff @(posedge sys_clk_i) begin
		pin_s1_r <= {boot_sw_i, mem_type_i};
		pin_s2_r <= pin_s1_r;
	end
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			init_r <= 1'b1;
		end else begin
			init_r <= 1'b0;
		end
	end
	// ==========================================================
	// register file and port qualification
	logic [15:0] word_r [NUM_WORDS];
	mode_t mode_r;
	fsm_t state_r;
	logic host_wr, cmd_wr, hr_req, loc_take, host_store;
	assign host_wr = host_req_i & host_we_i;
	assign hr_req = host_wr & (host_addr_i == IDX_CMD) & host_wdata_i[CMD_HR_BIT];
	assign cmd_wr = host_wr & (host_addr_i == IDX_CMD) & file_enable_i & ~hr_req;
	assign host_store = host_wr & file_enable_i & (host_addr_i != IDX_ERR) & ~hr_req;
	assign loc_take = loc_req_i & ~(host_req_i & (host_addr_i == loc_addr_i));
	// ==========================================================
	// command decode
	logic d_done, d_cerr, d_w2_we, d_w3_we, d_shm_on, d_shm_off, d_nmi_off;
	logic [15:0] d_w2, d_w3, d_arg3;
	op_t d_op;
	mode_t d_mode;
	logic [15:0] w;
	function automatic logic one_hot(input logic [10:0] v);
		logic seen;
		logic bad;
		seen = 1'b0;
		bad = 1'b0;
		for (int i = 0; i < SEL_W; i++) begin
			bad = bad | (seen & v[i]);
			seen = seen | v[i];
		end
		return seen & ~bad;
	endfunction : one_hot
	assign w = host_wdata_i;
	always_comb begin
		d_done = 1'b0;
		d_cerr = 1'b0;
		d_w2_we = 1'b0;
		d_w3_we = 1'b0;
		d_w2 = word_r[IDX_PAR];
		d_w3 = word_r[IDX_PAR2];
		d_arg3 = word_r[IDX_PAR2];
		d_shm_on = 1'b0;
		d_shm_off = 1'b0;
		d_nmi_off = 1'b0;
		d_op = OP_NONE;
		d_mode = mode_r;
		if (mode_r == MODE_DEBUG) begin
			if (w[DBG_EXIT]) begin
				d_mode = MODE_CTRL;
				d_done = 1'b1;
			end else if (w[DBG_PROCEED]) begin
				d_mode = MODE_CTRL;
				d_op = OP_DBG_PROCEED;
			end else if (w[DBG_GO]) begin
				d_mode = MODE_CTRL;
				d_nmi_off = 1'b1;
				d_op = OP_DBG_GO;
			end else if (w[DBG_DEPOSIT]) begin
				d_op = OP_DBG_DEPOSIT;
			end else if (w[DBG_REG]) begin
				d_cerr = word_r[IDX_PAR2] > DBG_REG_LAST;
				d_done = d_cerr;
				d_op = d_cerr ? OP_NONE : OP_DBG_REG;
			end else if (w[DBG_MEM]) begin
				d_op = OP_DBG_MEM;
			end
		end else if (w[CMD_TEST_BIT]) begin
			d_mode = MODE_TEST;
			if (one_hot(w[10:0])) begin
				d_op = OP_TEST;
			end else if (w[10:0] != 11'h000) begin
				d_cerr = 1'b1;
				d_done = 1'b1;
			end
		end else begin
			d_mode = MODE_CTRL;
			if (w[10:0] == 11'h000) begin
				d_done = 1'b0;
			end else if (!one_hot(w[10:0])) begin
				d_cerr = 1'b1;
				d_done = 1'b1;
			end else begin
				d_done = 1'b1;
				if (w[CTL_IDENT]) begin
					d_w2_we = 1'b1;
					d_w2 = BOARD_ID;
				end else if (w[CTL_SHM_DIS]) begin
					d_cerr = ~shm_enable_o;
					d_shm_off = 1'b1;
				end else if (w[CTL_SHM_REP]) begin
					d_cerr = ~shm_enable_o;
					d_w2_we = shm_enable_o;
					d_w3_we = shm_enable_o;
					d_w2 = {6'h00, shm_base_o};
					d_w3 = shm_blocks_o;
				end else if (w[CTL_SHM_EN]) begin
					d_shm_on = 1'b1;
				end else if (w[CTL_CFG_REP]) begin
					d_w3_we = 1'b1;
					d_w3 = {8'h00, pin_s2_r[5:2], 1'b0, pin_s2_r[1:0], 1'b0};
				end else if (w[CTL_DEBUG]) begin
					d_mode = MODE_DEBUG;
				end else if (w[CTL_RESTART]) begin
					d_cerr = word_r[IDX_PAR2] > RESTART_USE_SWITCH;
					d_done = d_cerr;
					d_op = d_cerr ? OP_NONE : OP_RESTART;
					if (word_r[IDX_PAR2] == RESTART_USE_SWITCH) begin
						d_arg3 = {12'h000, pin_s2_r[5:2]};
					end
				end else if (w[CTL_DMA]) begin
					d_done = 1'b0;
					d_op = OP_DMA;
				end else if (w[CTL_TRAP]) begin
					d_done = 1'b0;
					d_op = OP_TRAP;
				end
			end
		end
	end
	// ==========================================================
	// operation sequencer
	logic res_w2_we, res_w3_we, res_cerr, res_dma;
	logic [15:0] res_w2, res_w3;
	logic [3:0] zero_idx_r;
	logic trig;
	assign trig = cmd_wr & (state_r == ST_IDLE);
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			mode_r <= MODE_CTRL;
			ext_start_o <= 1'b0;
			ext_op_o <= OP_NONE;
			ext_sel_o <= 11'h000;
			ext_arg2_o <= WORD_RESET;
			ext_arg3_o <= WORD_RESET;
			{res_w2_we, res_w3_we, res_cerr, res_dma} <= 4'h0;
			res_w2 <= WORD_RESET;
			res_w3 <= WORD_RESET;
			zero_idx_r <= IDX_USER_FIRST;
		end else if (hr_req) begin
			state_r <= ST_IDLE;
			mode_r <= MODE_CTRL;
			ext_start_o <= 1'b0;
			ext_op_o <= OP_NONE;
		end else begin
			ext_start_o <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (trig) begin
						mode_r <= d_mode;
						{res_w2_we, res_w3_we, res_cerr, res_dma} <= {d_w2_we, d_w3_we, d_cerr, 1'b0};
						res_w2 <= d_w2;
						res_w3 <= d_w3;
						ext_op_o <= d_op;
						ext_sel_o <= w[10:0];
						ext_arg2_o <= word_r[IDX_PAR];
						ext_arg3_o <= d_arg3;
						if (d_op != OP_NONE) begin
							ext_start_o <= 1'b1;
							state_r <= ST_WAIT;
						end else if (d_done) begin
							state_r <= ST_DONE;
						end
					end
				end
				ST_WAIT: begin
					if (ext_done_i) begin
						res_w2 <= (ext_op_o == OP_TEST) ? {5'h00, ext_status_i[10:0]} : ext_status_i;
						res_w2_we <= (ext_op_o inside {OP_TEST, OP_DMA, OP_DBG_REG, OP_DBG_MEM});
						res_dma <= (ext_op_o == OP_DMA);
						res_cerr <= ext_fail_i & (ext_op_o != OP_TEST);
						zero_idx_r <= IDX_USER_FIRST;
						state_r <= (ext_op_o == OP_TEST && ext_sel_o[TEST_REGFILE]) ? ST_ZERO : ST_DONE;
					end
				end
				ST_ZERO: begin
					zero_idx_r <= zero_idx_r + 4'h1;
					if (zero_idx_r == IDX_LAST) begin
						state_r <= ST_DONE;
					end
				end
				ST_DONE: begin
					state_r <= ST_IDLE;
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end
	// ==========================================================
	// word storage: host, local, then sequencer results
	logic [15:0] host_val;
	assign host_val = (mode_r != MODE_DEBUG && w[CMD_TEST_BIT]) ? (w & ~TEST_UNUSED_MASK) : w;
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_WORDS; i++) begin
				word_r[i] <= WORD_RESET;
			end
		end else if (hr_req || init_r) begin
			for (int i = 0; i < NUM_WORDS; i++) begin
				word_r[i] <= WORD_RESET;
			end
			word_r[IDX_ERR][2:0] <= STATE_IDLE;
			word_r[IDX_PAR2][7:4] <= pin_s2_r[5:2];
		end else begin
			if (host_store) begin
				word_r[host_addr_i] <= (host_addr_i == IDX_CMD) ? host_val : w;
			end
			if (loc_take && loc_we_i) begin
				word_r[loc_addr_i] <= loc_wdata_i;
			end
			if (state_r == ST_ZERO) begin
				word_r[zero_idx_r] <= WORD_RESET;
			end
			if (state_r == ST_DONE) begin
				word_r[IDX_CMD] <= WORD_RESET;
				if (res_w2_we) word_r[IDX_PAR] <= res_w2;
				if (res_w3_we) word_r[IDX_PAR2] <= res_w3;
				word_r[IDX_ERR][ERR_CMD_BIT] <= word_r[IDX_ERR][ERR_CMD_BIT] | res_cerr;
				word_r[IDX_ERR][ERR_DMA_BIT] <= word_r[IDX_ERR][ERR_DMA_BIT] | res_dma;
				word_r[IDX_ERR][2:0] <= (mode_r == MODE_DEBUG) ? STATE_DEBUG : STATE_IDLE;
			end
		end
	end
	assign board_state_o = word_r[IDX_ERR][2:0];
	// ==========================================================
	// port answers, one cycle after the request
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			host_ack_o <= 1'b0;
			host_timeout_o <= 1'b0;
			host_rdata_o <= WORD_RESET;
			loc_ack_o <= 1'b0;
			loc_rdata_o <= WORD_RESET;
		end else begin
			host_timeout_o <= host_wr & ~file_enable_i & (host_addr_i != IDX_CMD);
			host_ack_o <= host_req_i & ~(host_wr & ~file_enable_i & (host_addr_i != IDX_CMD));
			host_rdata_o <= file_enable_i ? word_r[host_addr_i] : WORD_RESET;
			loc_ack_o <= loc_take;
			loc_rdata_o <= word_r[loc_addr_i];
		end
	end
	// ==========================================================
	// NMI enable, hard reset pulse, shared memory settings
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			nmi_enable_o <= 1'b0;
			hard_reset_o <= 1'b0;
		end else begin
			hard_reset_o <= hr_req;
			if (hr_req || sw_reset_i || (trig && d_nmi_off)) begin
				nmi_enable_o <= 1'b0;
			end else if (nmi_arm_i) begin
				nmi_enable_o <= 1'b1;
			end
		end
	end
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			shm_enable_o <= 1'b0;
			shm_base_o <= 10'h000;
			shm_blocks_o <= WORD_RESET;
		end else if (hr_req) begin
			shm_enable_o <= 1'b0;
		end else if (trig && d_shm_off) begin
			shm_enable_o <= 1'b0;
		end else if (trig && d_shm_on) begin
			shm_enable_o <= 1'b1;
			shm_base_o <= word_r[IDX_PAR2][SHM_BASE_W-1:0];
			shm_blocks_o <= word_r[IDX_PAR];
		end
	end
	// ==========================================================
	// checks
	property p_hard_reset;
		@(posedge sys_clk_i) disable iff (!rst_n) hr_req |=> hard_reset_o && state_r == ST_IDLE;
	endproperty
	a_hard_reset: assert property (p_hard_reset) else $error("hard reset not taken");
	property p_timeout;
		@(posedge sys_clk_i) disable iff (!rst_n)
			host_wr && !file_enable_i && host_addr_i != IDX_CMD |=> host_timeout_o && !host_ack_o;
	endproperty
	a_timeout: assert property (p_timeout) else $error("disabled write did not time out");
	property p_dis_read;
		@(posedge sys_clk_i) disable iff (!rst_n)
			host_req_i && !host_we_i && !file_enable_i |=> host_ack_o && host_rdata_o == 16'h0000;
	endproperty
	a_dis_read: assert property (p_dis_read) else $error("disabled read not zero");
	property p_clear_cmd;
		@(posedge sys_clk_i) disable iff (!rst_n)
			state_r == ST_DONE && !hr_req |=> word_r[IDX_CMD] == 16'h0000 && state_r == ST_IDLE;
	endproperty
	a_clear_cmd: assert property (p_clear_cmd) else $error("command word not cleared");
	property p_go_nmi;
		@(posedge sys_clk_i) disable iff (!rst_n)
			trig && mode_r == MODE_DEBUG && w[DBG_GO] && !w[DBG_EXIT] && !w[DBG_PROCEED]
			|=> !nmi_enable_o && ext_start_o && ext_op_o == OP_DBG_GO;
	endproperty
	a_go_nmi: assert property (p_go_nmi) else $error("debug go left NMI on");
	property p_test_bits;
		@(posedge sys_clk_i) disable iff (!rst_n)
			host_store && host_addr_i == IDX_CMD && w[CMD_TEST_BIT] && mode_r != MODE_DEBUG
			|=> (word_r[IDX_CMD] & TEST_UNUSED_MASK) == 16'h0000;
	endproperty
	a_test_bits: assert property (p_test_bits) else $error("test bits 14:11 not zero");
	property p_collide;
		@(posedge sys_clk_i) disable iff (!rst_n)
			host_req_i && loc_req_i && host_addr_i == loc_addr_i
			|=> !loc_ack_o && (host_ack_o != host_timeout_o);
	endproperty
	a_collide: assert property (p_collide) else $error("collision not serialized");
	property p_zero;
		@(posedge sys_clk_i) disable iff (!rst_n)
			state_r == ST_ZERO && zero_idx_r == IDX_LAST && !hr_req
			|=> state_r == ST_DONE && word_r[IDX_LAST] == 16'h0000 && word_r[IDX_USER_FIRST] == 16'h0000;
	endproperty
	a_zero: assert property (p_zero) else $error("user words not zeroed");
	property p_err_ro;
		@(posedge sys_clk_i) disable iff (!rst_n)
			host_wr && host_addr_i == IDX_ERR && !(loc_take && loc_we_i) && state_r == ST_IDLE
			|=> $stable(word_r[IDX_ERR]);
	endproperty
	a_err_ro: assert property (p_err_ro) else $error("host changed error word");
	c_debug: cover property (@(posedge sys_clk_i) disable iff (!rst_n) mode_r == MODE_DEBUG);
	c_dma: cover property (@(posedge sys_clk_i) disable iff (!rst_n)
		state_r == ST_WAIT && ext_op_o == OP_DMA && ext_done_i);
	c_zero: cover property (@(posedge sys_clk_i) disable iff (!rst_n) state_r == ST_ZERO);
endmodule : two_port_command_mailbox

// ==== host_arbiter_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// host bus arbiter: one request cycle, answer one cycle later
module host_arbiter_model (
	input wire logic sys_clk_i, // board clock
	input wire logic host_ack_i, // access done
	input wire logic host_timeout_i, // write refused
	input wire logic [15:0] host_rdata_i, // read data
	output logic host_req_o, // access request
	output logic host_we_o, // write
	output logic [3:0] host_addr_o, // word index
	output logic [15:0] host_wdata_o // write data
);
	initial begin
		host_req_o = 1'b0;
		host_we_o = 1'b0;
		host_addr_o = 4'h0;
		host_wdata_o = 16'h0000;
	end
	// entered and left 2 ns after a rising edge
	task automatic xfer(input logic we, input logic [3:0] a, input logic [15:0] d,
		output logic [15:0] r, output logic tmo, output logic ack);
		host_req_o = 1'b1;
		host_we_o = we;
		host_addr_o = a;
		host_wdata_o = d;
		@(posedge sys_clk_i);
		#2;
		r = host_rdata_i; // answer stands only in the cycle after the taking edge
		tmo = host_timeout_i;
		ack = host_ack_i;
		host_req_o = 1'b0;
		host_we_o = ~we;
		host_addr_o = ~a;
		host_wdata_o = ~d; // released: no stale value
		@(posedge sys_clk_i);
		#2;
	endtask : xfer
endmodule : host_arbiter_model

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	import mailbox_pkg::*;
	localparam logic [15:0] ID = 16'h00A5;
	logic sys_clk_i, rstn_i, file_enable_i, host_req_i, host_we_i, loc_req_i, loc_we_i;
	logic [3:0] host_addr_i, loc_addr_i, boot_sw_i;
	logic [15:0] host_wdata_i, loc_wdata_i, ext_status_i, resp, last_sel, last_a2, last_a3;
	logic [1:0] mem_type_i;
	logic sw_reset_i, nmi_arm_i, ext_done_i, ext_fail_i, hr_seen;
	wire host_ack_o, host_timeout_o, loc_ack_o, nmi_enable_o, hard_reset_o, ext_start_o;
	wire shm_enable_o;
	wire [15:0] host_rdata_o, loc_rdata_o, ext_arg2_o, ext_arg3_o, shm_blocks_o;
	wire [10:0] ext_sel_o;
	wire [9:0] shm_base_o;
	wire [2:0] board_state_o;
	op_t ext_op_o, last_op;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	two_port_command_mailbox DUT (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
		.file_enable_i(file_enable_i), .host_req_i(host_req_i), .host_we_i(host_we_i),
		.host_addr_i(host_addr_i), .host_wdata_i(host_wdata_i), .host_ack_o(host_ack_o),
		.host_timeout_o(host_timeout_o), .host_rdata_o(host_rdata_o), .loc_req_i(loc_req_i),
		.loc_we_i(loc_we_i), .loc_addr_i(loc_addr_i), .loc_wdata_i(loc_wdata_i),
		.loc_ack_o(loc_ack_o), .loc_rdata_o(loc_rdata_o), .boot_sw_i(boot_sw_i),
		.mem_type_i(mem_type_i), .sw_reset_i(sw_reset_i), .nmi_arm_i(nmi_arm_i),
		.nmi_enable_o(nmi_enable_o), .hard_reset_o(hard_reset_o), .ext_start_o(ext_start_o),
		.ext_op_o(ext_op_o), .ext_sel_o(ext_sel_o), .ext_arg2_o(ext_arg2_o),
		.ext_arg3_o(ext_arg3_o), .ext_done_i(ext_done_i), .ext_fail_i(ext_fail_i),
		.ext_status_i(ext_status_i), .shm_enable_o(shm_enable_o), .shm_base_o(shm_base_o),
		.shm_blocks_o(shm_blocks_o), .board_state_o(board_state_o));
	host_arbiter_model arb (.sys_clk_i(sys_clk_i), .host_ack_i(host_ack_o),
		.host_timeout_i(host_timeout_o), .host_rdata_i(host_rdata_o), .host_req_o(host_req_i),
		.host_we_o(host_we_i), .host_addr_o(host_addr_i), .host_wdata_o(host_wdata_i));
	initial begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	// ==========================================================
	// external operation engine: done three cycles after start
	initial begin
		ext_done_i = 1'b0;
		ext_fail_i = 1'b0;
		ext_status_i = 16'h0000;
		forever begin
			@(posedge sys_clk_i);
			#1;
			if (ext_start_o === 1'b1) begin
				last_op = ext_op_o;
				last_sel = {5'h00, ext_sel_o};
				last_a2 = ext_arg2_o;
				last_a3 = ext_arg3_o;
				repeat (3) @(posedge sys_clk_i);
				#1;
				ext_done_i = 1'b1;
				ext_status_i = resp;
				@(posedge sys_clk_i);
				#2;
				ext_done_i = 1'b0;
				ext_status_i = ~resp;
			end
		end
	end
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (hard_reset_o === 1'b1) hr_seen <= 1'b1;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end
	// ==========================================================
	// shared tasks
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		logic [15:0] r;
		logic t;
		logic k;
		arb.xfer(1'b1, a, d, r, t, k);
		chk("write ack", 16'h0001, {15'h0, k});
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [15:0] r);
		logic t;
		logic k;
		arb.xfer(1'b0, a, 16'h0000, r, t, k);
		chk("read ack", 16'h0001, {15'h0, k});
	endtask : rd
	task automatic rdchk(input string nm, input logic [3:0] a, input logic [15:0] exp);
		logic [15:0] r;
		rd(a, r);
		chk(nm, exp, r);
	endtask : rdchk
	// polls only: parameter words stay untouched while busy
	task automatic wait_idle;
		logic [15:0] r;
		r = 16'hFFFF;
		for (int i = 0; i < 40 && r !== 16'h0000; i++) rd(IDX_CMD, r);
		chk("cmd word", 16'h0000, r);
	endtask : wait_idle
	task automatic cmd(input logic [15:0] c);
		wr(IDX_CMD, c);
		wait_idle();
	endtask : cmd
	task automatic loc_wr(input logic [3:0] a, input logic [15:0] d);
		logic ok;
		ok = 1'b0;
		for (int i = 0; i < 4 && !ok; i++) begin
			loc_req_i = 1'b1;
			loc_we_i = 1'b1;
			loc_addr_i = a;
			loc_wdata_i = d;
			@(posedge sys_clk_i);
			#2;
			ok = (loc_ack_o === 1'b1);
			loc_req_i = 1'b0;
			loc_wdata_i = ~d;
			@(posedge sys_clk_i);
			#2;
		end
		chk("local ack", 16'h0001, {15'h0, ok});
	endtask : loc_wr
	task automatic loc_rdchk(input string nm, input logic [3:0] a, input logic [15:0] exp);
		loc_req_i = 1'b1;
		loc_we_i = 1'b0;
		loc_addr_i = a;
		@(posedge sys_clk_i);
		#2;
		chk(nm, exp, loc_rdata_o);
		loc_req_i = 1'b0;
		@(posedge sys_clk_i);
		#2;
	endtask : loc_rdchk
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(posedge sys_clk_i);
		#2;
		s = 1'b0;
		@(posedge sys_clk_i);
		#2;
	endtask : pulse
	// ==========================================================
	// scenarios
	task automatic t_reset_disabled;
		logic [15:0] r;
		logic t;
		logic k;
		rdchk("state", IDX_ERR, 16'h0004);
		rdchk("boot in word3", IDX_PAR2, 16'h00A0);
		file_enable_i = 1'b0;
		arb.xfer(1'b1, 4'h5, 16'h1234, r, t, k);
		chk("timeout", 16'h0001, {15'h0, t});
		chk("timeout no ack", 16'h0000, {15'h0, k});
		arb.xfer(1'b1, IDX_CMD, 16'h0000, r, t, k);
		chk("cmd no timeout", 16'h0000, {15'h0, t});
		chk("cmd ack", 16'h0001, {15'h0, k});
		rdchk("disabled read", IDX_ERR, 16'h0000);
		file_enable_i = 1'b1;
		wr(IDX_ERR, 16'hFFFF);
		rdchk("err word ro", IDX_ERR, 16'h0004);
		$display("reset and disabled test done");
	endtask : t_reset_disabled
	task automatic t_control;
		cmd(16'h0400);
		rdchk("identify", IDX_PAR, ID);
		wr(IDX_PAR, 16'h0003);
		wr(IDX_PAR2, 16'h0155);
		cmd(16'h0040);
		chk("shm en", 16'h0001, {15'h0, shm_enable_o});
		chk("shm base", 16'h0155, {6'h00, shm_base_o});
		chk("shm blocks", 16'h0003, shm_blocks_o);
		wr(IDX_PAR, 16'h0000);
		wr(IDX_PAR2, 16'h0000);
		cmd(16'h0080);
		rdchk("report base", IDX_PAR, 16'h0155);
		rdchk("report pages", IDX_PAR2, 16'h0003);
		cmd(16'h0100);
		chk("shm off", 16'h0000, {15'h0, shm_enable_o});
		rdchk("no error", IDX_ERR, 16'h0004);
		cmd(16'h0100);
		rdchk("disable error", IDX_ERR, 16'h8004);
		loc_wr(IDX_ERR, 16'h0004);
		cmd(16'h0003);
		rdchk("two bits error", IDX_ERR, 16'h8004);
		loc_wr(IDX_ERR, 16'h0004);
		wr(IDX_PAR2, 16'h0000);
		cmd(16'h0010);
		rdchk("config", IDX_PAR2, 16'h00A4);
		$display("control test done");
	endtask : t_control
	task automatic t_dma;
		resp = 16'h1234;
		wr(IDX_PAR, 16'h0011);
		wr(IDX_PAR2, 16'h0022);
		cmd(16'h0002);
		chk("dma op", {12'h000, OP_DMA}, {12'h000, last_op});
		chk("dma offset", 16'h0011, last_a2);
		chk("dma segment", 16'h0022, last_a3);
		rdchk("dma status", IDX_PAR, 16'h1234);
		rdchk("dma flag", IDX_ERR, 16'h4004);
		loc_wr(IDX_ERR, 16'h0004);
		wr(IDX_PAR2, 16'h0008);
		cmd(16'h0004);
		chk("restart op", {12'h000, OP_RESTART}, {12'h000, last_op});
		chk("restart sel", 16'h000A, last_a3);
		wr(IDX_PAR2, 16'h0009);
		cmd(16'h0004);
		rdchk("restart error", IDX_ERR, 16'h8004);
		loc_wr(IDX_ERR, 16'h0004);
		wr(IDX_PAR, 16'h1000);
		wr(IDX_PAR2, 16'h00E0);
		cmd(16'h0001);
		chk("trap op", {12'h000, OP_TRAP}, {12'h000, last_op});
		chk("trap pc", 16'h1000, last_a2);
		chk("trap status", 16'h00E0, last_a3);
		$display("dma test done");
	endtask : t_dma
	task automatic t_tests;
		logic [15:0] b;
		wr(IDX_PAR2, 16'h0001);
		wr(4'h5, 16'hBEEF);
		for (int i = 0; i < 11; i++) begin
			b = 16'h0001 << i;
			resp = i[0] ? b : 16'h0000;
			wr(IDX_CMD, 16'hB800 | b);
			rdchk("test word", IDX_CMD, 16'h8000 | b);
			wait_idle();
			chk("test sel", b, last_sel);
			rdchk("test result", IDX_PAR, resp);
		end
		rdchk("user word", 4'h5, 16'h0000);
		$display("self test loop done");
	endtask : t_tests
	task automatic t_collide;
		fork
			wr(IDX_PAR, 16'h1111);
			loc_wr(IDX_PAR, 16'h2222);
		join
		rdchk("collision", IDX_PAR, 16'h2222);
		loc_rdchk("local read", IDX_PAR, 16'h2222);
		$display("collision test done");
	endtask : t_collide
	task automatic t_debug_reset;
		cmd(16'h0008);
		chk("debug state", 16'h0003, {13'h0, board_state_o});
		cmd(16'h8000);
		chk("exit state", 16'h0004, {13'h0, board_state_o});
		cmd(16'h0008);
		pulse(nmi_arm_i);
		cmd(16'h0008);
		chk("go op", {12'h000, OP_DBG_GO}, {12'h000, last_op});
		chk("nmi go", 16'h0000, {15'h0, nmi_enable_o});
		chk("go state", 16'h0004, {13'h0, board_state_o});
		pulse(nmi_arm_i);
		chk("nmi on", 16'h0001, {15'h0, nmi_enable_o});
		pulse(sw_reset_i);
		chk("nmi sw", 16'h0000, {15'h0, nmi_enable_o});
		pulse(nmi_arm_i);
		file_enable_i = 1'b0;
		hr_seen = 1'b0;
		wr(IDX_CMD, 16'h4000);
		repeat (4) @(posedge sys_clk_i);
		#2;
		file_enable_i = 1'b1;
		chk("hard reset", 16'h0001, {15'h0, hr_seen});
		chk("nmi hard", 16'h0000, {15'h0, nmi_enable_o});
		rdchk("after reset", IDX_PAR, 16'h0000);
		$display("debug and reset test done");
	endtask : t_debug_reset
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict
	initial begin
		rstn_i = 1'b0;
		file_enable_i = 1'b1;
		loc_req_i = 1'b0;
		loc_we_i = 1'b0;
		loc_addr_i = 4'h0;
		loc_wdata_i = 16'h0000;
		boot_sw_i = 4'hA;
		mem_type_i = 2'b10;
		sw_reset_i = 1'b0;
		nmi_arm_i = 1'b0;
		resp = 16'h0000;
		hr_seen = 1'b0;
		repeat (8) @(posedge sys_clk_i);
		#2;
		rstn_i = 1'b1;
		repeat (4) @(posedge sys_clk_i);
		#2;
		t_reset_disabled();
		t_control();
		t_dma();
		t_tests();
		t_collide();
		t_debug_reset();
		print_verdict();
	end
endmodule : tb_top
